/* File: tacb_map.svh */
// tacb_map.svh: offsets, field positions and initial image of the trim bank
// assumes: included by the package and the design modules by bare name
`ifndef TACB_MAP_SVH
`define TACB_MAP_SVH

// ****************************************
// register indices (byte address = 4 * index)
// ****************************************
`define TACB_IDX_REF_RSVD   18'h0_0025
`define TACB_IDX_OSC_TRIM   18'h0_0026
`define TACB_IDX_FLT_A      18'h0_0027
`define TACB_IDX_FLT_B      18'h0_0028
`define TACB_IDX_CAL_HIGH   18'h0_FE60
`define TACB_IDX_CAL_LOW    18'h0_FE61

// ****************************************
// field positions
// ****************************************
`define TACB_FAST_TRIM_MSB  7
`define TACB_FAST_TRIM_LSB  4
`define TACB_SLOW_TRIM_MSB  3
`define TACB_SLOW_TRIM_LSB  0
`define TACB_CAL_SIGN_BIT   2
`define TACB_CAL_MAG_HI_MSB 1

// ****************************************
// nonvolatile image at power-up; reset never reloads it
// ****************************************
`define TACB_INIT_REF_RSVD  8'hFF
`define TACB_INIT_OSC_TRIM  8'h88
`define TACB_INIT_FLT_A     8'hFF
`define TACB_INIT_FLT_B     8'hFF
`define TACB_INIT_CAL_HIGH  8'h00
`define TACB_INIT_CAL_LOW   8'h00

// ****************************************
// bus answers and defaults
// ****************************************
`define TACB_RESP_OKAY      2'h0
`define TACB_RESP_SLVERR    2'h2
`define TACB_ADDR_W         18
`define TACB_ADC_W          12
`define TACB_ADC_W_MAX      16
`define TACB_CAL_W          10

`endif

/* File: tacb_pkg.sv */
// tacb_pkg.sv: types shared by the trim bank modules
// assumes: tacb_map.svh is on the include path
`include "tacb_map.svh"

package tacb_pkg;

  // register selector; SEL_NONE marks an unmapped address
  typedef enum logic [2:0] {
    SEL_REF,
    SEL_OSC,
    SEL_FLT_A,
    SEL_FLT_B,
    SEL_CAL_H,
    SEL_CAL_L,
    SEL_NONE
  } tacb_sel_t;

  typedef logic [5:0][7:0] tacb_bytes_t;

  typedef struct packed {
    tacb_bytes_t bytes;
  } tacb_store_t;

  typedef struct packed {
    logic                          aw_rdy;
    logic                          w_rdy;
    logic                          aw_hold;
    logic                          w_hold;
    logic [`TACB_ADDR_W-1:0]       wr_addr;
    logic [7:0]                    wr_data;
    logic                          wr_strb;
    logic                          bvalid;
    logic [1:0]                    bresp;
    logic                          ar_rdy;
    logic                          rvalid;
    logic [31:0]                   rdata;
    logic [1:0]                    rresp;
    logic [`TACB_ADC_W_MAX-1:0]    temp_out;
    logic                          temp_vld;
  } tacb_state_t;

endpackage

/* File: tacb_store.sv */
// tacb_store.sv: nonvolatile trim and calibration bytes
// assumes: write strobe and data come from logic on the same clock
`timescale 1ns/100ps
`include "tacb_map.svh"

module tacb_store (
  // clock
  input  wire logic                 mclk_i,
  // write port
  input  wire logic                 wr_en_i,
  input  wire tacb_pkg::tacb_sel_t  wr_sel_i,
  input  wire logic [7:0]           wr_data_i,
  // stored image
  output tacb_pkg::tacb_bytes_t     bytes_o
);

  // ****************************************
  // storage
  // ****************************************
  // no reset here
  // the image models flash content: it is set once at power-up and only
  // software writes change it, so a reset pulse leaves every byte alone
  tacb_pkg::tacb_store_t st_reg = '{bytes: {`TACB_INIT_CAL_LOW,
                                            `TACB_INIT_CAL_HIGH,
                                            `TACB_INIT_FLT_B,
                                            `TACB_INIT_FLT_A,
                                            `TACB_INIT_OSC_TRIM,
                                            `TACB_INIT_REF_RSVD}};
  tacb_pkg::tacb_store_t st_next;

  always_comb
  begin
    st_next = st_reg;
    if (wr_en_i && wr_sel_i != tacb_pkg::SEL_NONE)
    begin
      st_next.bytes[wr_sel_i] = wr_data_i;
    end
  end

  always_ff @(posedge mclk_i)
  begin
    st_reg <= st_next;
  end

  assign bytes_o = st_reg.bytes;

endmodule

/* File: tacb_trim_bank.sv */
// tacb_trim_bank.sv: trim and temperature calibration bank, AXI4-Lite slave
// assumes: one AXI4-Lite master on mclk_i; temperature samples on mclk_i
//
// Register access over AXI4-Lite was left to the implementer.
`timescale 1ns/100ps
`include "tacb_map.svh"

// Overview of operation
// - Fast crystal trim code comes from oscillator trim bits 7 to 4.
// - Slow crystal trim code comes from oscillator trim bits 3 to 0.
// - Trim and calibration bytes keep their contents across reset.
// - Calibration high bits 7 to 3 have no function.
// - Calibration high bit 2: zero adds magnitude, one subtracts it.
// - Magnitude is high byte bits 1..0 followed by the whole low byte.
module tacb_trim_bank #(
  parameter int ADDR_W = `TACB_ADDR_W,
  parameter int ADC_W  = `TACB_ADC_W
) (
  // clock and reset
  input  wire logic              mclk_i,
  input  wire logic              resetn_i,
  // axi4-lite write address
  input  wire logic              s_axi_awvalid_i,
  output logic                   s_axi_awready_o,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr_i,
  input  wire logic [2:0]        s_axi_awprot_i,
  // axi4-lite write data
  input  wire logic              s_axi_wvalid_i,
  output logic                   s_axi_wready_o,
  input  wire logic [31:0]       s_axi_wdata_i,
  input  wire logic [3:0]        s_axi_wstrb_i,
  // axi4-lite write response
  output logic                   s_axi_bvalid_o,
  input  wire logic              s_axi_bready_i,
  output logic [1:0]             s_axi_bresp_o,
  // axi4-lite read address
  input  wire logic              s_axi_arvalid_i,
  output logic                   s_axi_arready_o,
  input  wire logic [ADDR_W-1:0] s_axi_araddr_i,
  input  wire logic [2:0]        s_axi_arprot_i,
  // axi4-lite read data
  output logic                   s_axi_rvalid_o,
  input  wire logic              s_axi_rready_i,
  output logic [31:0]            s_axi_rdata_o,
  output logic [1:0]             s_axi_rresp_o,
  // oscillator trims
  output logic [3:0]             fast_crystal_trim_code_o,
  output logic [3:0]             slow_crystal_trim_code_o,
  // temperature calibration
  output logic                   temp_cal_subtract_o,
  output logic [9:0]             temp_cal_magnitude_o,
  input  wire logic              temp_adc_valid_i,
  input  wire logic [ADC_W-1:0]  temp_adc_i,
  output logic                   temp_corrected_valid_o,
  output logic [ADC_W-1:0]       temp_corrected_o
);

  // ****************************************
  // elaboration checks
  // ****************************************
  // the held write address is a fixed-width field: a wider bus would
  // alias upper address bits on writes while reads still refuse them
  if (ADDR_W != `TACB_ADDR_W)
  begin : g_bad_addr
    $error("address width must match the held write address");
  end
  if (ADC_W < `TACB_CAL_W || ADC_W > `TACB_ADC_W_MAX)
  begin : g_bad_adc
    $error("sample width must lie between 10 and 16 bits");
  end

  // ****************************************
  // address decode
  // ****************************************
  function automatic tacb_pkg::tacb_sel_t decode(
    input logic [ADDR_W-1:0] addr
  );
    logic [ADDR_W-1:0] idx;
    idx = addr >> 2;
    decode = tacb_pkg::SEL_NONE;
    if (addr[1:0] == 2'h0)
    begin
      unique case (idx)
        ADDR_W'(`TACB_IDX_REF_RSVD): decode = tacb_pkg::SEL_REF;
        ADDR_W'(`TACB_IDX_OSC_TRIM): decode = tacb_pkg::SEL_OSC;
        ADDR_W'(`TACB_IDX_FLT_A):    decode = tacb_pkg::SEL_FLT_A;
        ADDR_W'(`TACB_IDX_FLT_B):    decode = tacb_pkg::SEL_FLT_B;
        ADDR_W'(`TACB_IDX_CAL_HIGH): decode = tacb_pkg::SEL_CAL_H;
        ADDR_W'(`TACB_IDX_CAL_LOW):  decode = tacb_pkg::SEL_CAL_L;
        default:                     decode = tacb_pkg::SEL_NONE;
      endcase
    end
  endfunction

  // ****************************************
  // state and store
  // ****************************************
  tacb_pkg::tacb_state_t st_reg;
  tacb_pkg::tacb_state_t st_next;
  tacb_pkg::tacb_bytes_t bytes;
  tacb_pkg::tacb_sel_t   wr_sel;
  tacb_pkg::tacb_sel_t   rd_sel;
  logic                  wr_go;
  logic [9:0]            cal_mag;
  logic                  cal_sub;

  assign wr_sel = decode(st_reg.wr_addr[ADDR_W-1:0]);
  assign rd_sel = decode(s_axi_araddr_i);
  // commit once both halves are held and no answer is outstanding
  assign wr_go  = st_reg.aw_hold && st_reg.w_hold && !st_reg.bvalid;

  // all register bits are writable storage; lane 0 carries the byte
  tacb_store u_store (
    .mclk_i    (mclk_i),
    .wr_en_i   (wr_go && st_reg.wr_strb),
    .wr_sel_i  (wr_sel),
    .wr_data_i (st_reg.wr_data),
    .bytes_o   (bytes)
  );

  assign cal_sub = bytes[tacb_pkg::SEL_CAL_H][`TACB_CAL_SIGN_BIT];
  assign cal_mag = {bytes[tacb_pkg::SEL_CAL_H][`TACB_CAL_MAG_HI_MSB:0],
                    bytes[tacb_pkg::SEL_CAL_L]};

  // ****************************************
  // next state
  // ****************************************
  always_comb
  begin
    logic [ADC_W-1:0] mag_ext;
    mag_ext = '0;
    st_next = st_reg;

    // write address and data taken in either order
    if (s_axi_awvalid_i && st_reg.aw_rdy)
    begin
      st_next.aw_rdy  = 1'b0;
      st_next.aw_hold = 1'b1;
      st_next.wr_addr = ($bits(st_next.wr_addr))'(s_axi_awaddr_i);
    end
    if (s_axi_wvalid_i && st_reg.w_rdy)
    begin
      st_next.w_rdy   = 1'b0;
      st_next.w_hold  = 1'b1;
      st_next.wr_data = s_axi_wdata_i[7:0];
      st_next.wr_strb = s_axi_wstrb_i[0];
    end
    if (wr_go)
    begin
      st_next.bvalid = 1'b1;
      st_next.bresp  = (wr_sel == tacb_pkg::SEL_NONE) ?
                       `TACB_RESP_SLVERR : `TACB_RESP_OKAY;
    end
    if (st_reg.bvalid && s_axi_bready_i)
    begin
      st_next.bvalid  = 1'b0;
      st_next.aw_hold = 1'b0;
      st_next.w_hold  = 1'b0;
      st_next.aw_rdy  = 1'b1;
      st_next.w_rdy   = 1'b1;
    end

    // read: unmapped words answer zero with slave error
    if (s_axi_arvalid_i && st_reg.ar_rdy)
    begin
      st_next.ar_rdy = 1'b0;
      st_next.rvalid = 1'b1;
      if (rd_sel == tacb_pkg::SEL_NONE)
      begin
        st_next.rdata = 32'h0000_0000;
        st_next.rresp = `TACB_RESP_SLVERR;
      end
      else
      begin
        st_next.rdata = {24'h00_0000, bytes[rd_sel]};
        st_next.rresp = `TACB_RESP_OKAY;
      end
    end
    if (st_reg.rvalid && s_axi_rready_i)
    begin
      st_next.rvalid = 1'b0;
      st_next.ar_rdy = 1'b1;
    end

    // zero-extend before correcting
    // result wraps modulo the sample width; no saturation is applied
    mag_ext = ADC_W'(cal_mag);
    st_next.temp_vld = temp_adc_valid_i;
    if (temp_adc_valid_i)
    begin
      st_next.temp_out = cal_sub ?
        ($bits(st_next.temp_out))'(temp_adc_i - mag_ext) :
        ($bits(st_next.temp_out))'(temp_adc_i + mag_ext);
    end
  end

  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      st_reg <= '{aw_rdy: 1'b1, w_rdy: 1'b1, ar_rdy: 1'b1, default: '0};
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign s_axi_awready_o        = st_reg.aw_rdy;
  assign s_axi_wready_o         = st_reg.w_rdy;
  assign s_axi_bvalid_o         = st_reg.bvalid;
  assign s_axi_bresp_o          = st_reg.bresp;
  assign s_axi_arready_o        = st_reg.ar_rdy;
  assign s_axi_rvalid_o         = st_reg.rvalid;
  assign s_axi_rdata_o          = st_reg.rdata;
  assign s_axi_rresp_o          = st_reg.rresp;
  assign fast_crystal_trim_code_o =
    bytes[tacb_pkg::SEL_OSC][`TACB_FAST_TRIM_MSB:`TACB_FAST_TRIM_LSB];
  assign slow_crystal_trim_code_o =
    bytes[tacb_pkg::SEL_OSC][`TACB_SLOW_TRIM_MSB:`TACB_SLOW_TRIM_LSB];
  assign temp_cal_subtract_o    = cal_sub;
  assign temp_cal_magnitude_o   = cal_mag;
  assign temp_corrected_valid_o = st_reg.temp_vld;
  assign temp_corrected_o       = st_reg.temp_out[ADC_W-1:0];

endmodule

/* File: tacb_trim_bank_bench.sv */
// tacb_trim_bank_bench.sv: self-checking bench for the trim bank
// assumes: design and checker compiled first, default ADC_W of 12
`timescale 1ns/100ps
`include "tacb_map.svh"

module tacb_trim_bank_bench;
  // ****************************************
  // signals
  // ****************************************
  logic        mclk_i = 0, resetn_i = 0;
  logic        awv = 0, wv = 0, bry = 0, arv = 0, rry = 0, adcv = 0;
  logic [17:0] awa = 0, ara = 0;
  logic [31:0] wd = 0;
  logic [3:0]  ws = 0;
  logic [11:0] adc = 0;
  logic        awr, wr_, bv, arr, rv, sub, cv;
  logic [1:0]  br, rr;
  logic [31:0] rdat;
  logic [3:0]  fast, slow;
  logic [9:0]  mag;
  logic [11:0] cor;
  int          fail_count = 0, checks_done = 0, cyc = 0;
  logic [17:0] adr [6] = '{`TACB_IDX_REF_RSVD << 2, `TACB_IDX_OSC_TRIM << 2,
    `TACB_IDX_FLT_A << 2, `TACB_IDX_FLT_B << 2, `TACB_IDX_CAL_HIGH << 2,
    `TACB_IDX_CAL_LOW << 2};

  tacb_trim_bank i_tacb_trim_bank (
    .mclk_i(mclk_i), .resetn_i(resetn_i),
    .s_axi_awvalid_i(awv), .s_axi_awready_o(awr), .s_axi_awaddr_i(awa),
    .s_axi_awprot_i(3'h0), .s_axi_wvalid_i(wv), .s_axi_wready_o(wr_),
    .s_axi_wdata_i(wd), .s_axi_wstrb_i(ws), .s_axi_bvalid_o(bv),
    .s_axi_bready_i(bry), .s_axi_bresp_o(br), .s_axi_arvalid_i(arv),
    .s_axi_arready_o(arr), .s_axi_araddr_i(ara), .s_axi_arprot_i(3'h0),
    .s_axi_rvalid_o(rv), .s_axi_rready_i(rry), .s_axi_rdata_o(rdat),
    .s_axi_rresp_o(rr), .fast_crystal_trim_code_o(fast),
    .slow_crystal_trim_code_o(slow), .temp_cal_subtract_o(sub),
    .temp_cal_magnitude_o(mag), .temp_adc_valid_i(adcv), .temp_adc_i(adc),
    .temp_corrected_valid_o(cv), .temp_corrected_o(cor));

  always #5 mclk_i = ~mclk_i;

  // ****************************************
  // bus tasks
  // ****************************************
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e)
    begin
      fail_count++;
      $display("unexpected at %0t: got %h want %h", $time, s, e);
    end
  endtask

  task automatic wr(input logic [17:0] a, input logic [7:0] d,
                    input logic s, input logic [1:0] e);
    @(posedge mclk_i);
    awv <= 1;
    wv <= 1;
    awa <= a;
    wd <= {24'h0, d};
    ws <= {3'h0, s};
    // bready comes late so that the slave must hold its response
    do
    begin
      @(posedge mclk_i);
      if (awr)
        awv <= 0;
      if (wr_)
        wv <= 0;
    end
    while (!bv);
    bry <= 1;
    do
      @(posedge mclk_i);
    while (!bv);
    bry <= 0;
    chk(br, e);
  endtask

  task automatic rd(input logic [17:0] a, input logic [7:0] d,
                    input logic [1:0] e);
    @(posedge mclk_i);
    arv <= 1;
    ara <= a;
    rry <= 1;
    do
    begin
      @(posedge mclk_i);
      if (arr)
        arv <= 0;
    end
    while (!rv);
    rry <= 0;
    chk(rdat, {24'h0, d});
    chk(rr, e);
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_image;
    logic [7:0] img [6] = '{`TACB_INIT_REF_RSVD, `TACB_INIT_OSC_TRIM,
      `TACB_INIT_FLT_A, `TACB_INIT_FLT_B, `TACB_INIT_CAL_HIGH,
      `TACB_INIT_CAL_LOW};
    for (int i = 0; i < 6; i++)
      rd(adr[i], img[i], 2'h0);
    rd(18'h0_0090, 8'h00, 2'h2);
    rd(18'h0_0099, 8'h00, 2'h2);
    wr(18'h0_0090, 8'h12, 1'b1, 2'h2);
    // a refused write must not leave anything behind
    rd(18'h0_0090, 8'h00, 2'h2);
  endtask

  task automatic t_osc;
    wr(adr[0], 8'hFF, 1'b1, 2'h0);
    wr(adr[2], 8'h3C, 1'b1, 2'h0);
    wr(adr[3], 8'hC3, 1'b1, 2'h0);
    rd(adr[2], 8'h3C, 2'h0);
    rd(adr[3], 8'hC3, 2'h0);
    wr(adr[1], 8'h5A, 1'b1, 2'h0);
    chk(fast, 4'h5);
    chk(slow, 4'hA);
    // a cleared lane strobe must leave the byte alone
    wr(adr[1], 8'h00, 1'b0, 2'h0);
    chk(fast, 4'h5);
    rd(adr[1], 8'h5A, 2'h0);
  endtask

  task automatic t_cal;
    logic [7:0]  h [2] = '{8'hFB, 8'h06};
    logic [7:0]  l [2] = '{8'hFF, 8'h01};
    logic [11:0] x [2] = '{12'hE10, 12'h100};
    logic [9:0]  m;
    for (int i = 0; i < 2; i++)
    begin
      m = {h[i][1:0], l[i]};
      wr(adr[4], h[i], 1'b1, 2'h0);
      wr(adr[5], l[i], 1'b1, 2'h0);
      rd(adr[4], h[i], 2'h0);
      chk(sub, h[i][2]);
      chk(mag, m);
      @(posedge mclk_i);
      adcv <= 1;
      adc <= x[i];
      @(posedge mclk_i);
      adcv <= 0;
      #1;
      chk(cv, 1'b1);
      chk(cor, 12'(h[i][2] ? x[i] - m : x[i] + m));
      @(posedge mclk_i);
      #1;
      chk(cv, 1'b0);
    end
  endtask

  task automatic t_keep;
    @(posedge mclk_i);
    resetn_i <= 0;
    repeat (3) @(posedge mclk_i);
    chk(fast, 4'h5);
    chk(mag, 10'h201);
    resetn_i <= 1;
    rd(adr[1], 8'h5A, 2'h0);
    rd(adr[5], 8'h01, 2'h0);
  endtask

  task automatic finish_test;
    $display("checks %0d, mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  always @(posedge mclk_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      fail_count++;
      finish_test();
    end
  end

  initial
  begin
    repeat (20) @(posedge mclk_i);
    resetn_i <= 1;
    t_image();
    t_osc();
    t_cal();
    t_keep();
    finish_test();
  end
endmodule

/* File: tacb_trim_bank_chk.sv */
// tacb_trim_bank_chk.sv: port checks for the trim and calibration bank
// assumes: bound to tacb_trim_bank, single clock, low-active reset
`timescale 1ns/100ps
`include "tacb_map.svh"

module tacb_trim_bank_chk #(
  parameter int ADDR_W = 18,
  parameter int ADC_W  = 12
) (
  // clock and reset
  input wire logic              mclk_i,
  input wire logic              resetn_i,
  // write channels
  input wire logic              s_axi_awvalid_i,
  input wire logic              s_axi_awready_o,
  input wire logic [ADDR_W-1:0] s_axi_awaddr_i,
  input wire logic              s_axi_wvalid_i,
  input wire logic              s_axi_wready_o,
  input wire logic [31:0]       s_axi_wdata_i,
  input wire logic [3:0]        s_axi_wstrb_i,
  input wire logic              s_axi_bvalid_o,
  input wire logic              s_axi_bready_i,
  // trims and correction
  input wire logic [3:0]        fast_crystal_trim_code_o,
  input wire logic [3:0]        slow_crystal_trim_code_o,
  input wire logic              temp_cal_subtract_o,
  input wire logic [9:0]        temp_cal_magnitude_o,
  input wire logic              temp_adc_valid_i,
  input wire logic [ADC_W-1:0]  temp_adc_i,
  input wire logic              temp_corrected_valid_o,
  input wire logic [ADC_W-1:0]  temp_corrected_o
);
  // ****************************************
  // last accepted write, applied when bvalid rises
  // ****************************************
  localparam logic [ADDR_W-1:0] OSC = ADDR_W'(`TACB_IDX_OSC_TRIM) << 2;
  localparam logic [ADDR_W-1:0] CALH = ADDR_W'(`TACB_IDX_CAL_HIGH) << 2;
  localparam logic [ADDR_W-1:0] CALL = ADDR_W'(`TACB_IDX_CAL_LOW) << 2;
  logic [ADDR_W-1:0] aw_q;
  logic [7:0]        w_q;
  logic              s_q;

  always_ff @(posedge mclk_i)
  begin
    if (s_axi_awvalid_i && s_axi_awready_o)
      aw_q <= s_axi_awaddr_i;
    if (s_axi_wvalid_i && s_axi_wready_o)
    begin
      w_q <= s_axi_wdata_i[7:0];
      s_q <= s_axi_wstrb_i[0];
    end
  end

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!resetn_i);

  // ****************************************
  // assertions
  // ****************************************
  osc_trim_a: assert property (
    $rose(s_axi_bvalid_o) && s_q && aw_q == OSC
    |-> fast_crystal_trim_code_o == w_q[7:4]
    && slow_crystal_trim_code_o == w_q[3:0])
    else $error("osc trim wrong");
  trim_hold_a: assert property (
    $changed(fast_crystal_trim_code_o)
    || $changed(slow_crystal_trim_code_o)
    || $changed(temp_cal_magnitude_o)
    |-> $rose(s_axi_bvalid_o))
    else $error("trim moved without write");
  cal_high_a: assert property (
    $rose(s_axi_bvalid_o) && s_q && aw_q == CALH
    |-> temp_cal_subtract_o == w_q[2]
    && temp_cal_magnitude_o[9:8] == w_q[1:0])
    else $error("cal high fields wrong");
  cal_low_a: assert property (
    $rose(s_axi_bvalid_o) && s_q && aw_q == CALL
    |-> temp_cal_magnitude_o[7:0] == w_q)
    else $error("cal low wrong");
  corr_add_a: assert property (
    temp_adc_valid_i && !temp_cal_subtract_o
    |=> temp_corrected_valid_o && temp_corrected_o ==
    ADC_W'($past(temp_adc_i) + $past(temp_cal_magnitude_o)))
    else $error("added correction wrong");
  corr_sub_a: assert property (
    temp_adc_valid_i && temp_cal_subtract_o
    |=> temp_corrected_valid_o && temp_corrected_o ==
    ADC_W'($past(temp_adc_i) - $past(temp_cal_magnitude_o)))
    else $error("subtracted correction wrong");
  corr_pulse_a: assert property (
    !temp_adc_valid_i |=> !temp_corrected_valid_o)
    else $error("stray corrected valid");
  bresp_hold_a: assert property (s_axi_bvalid_o && !s_axi_bready_i
    |=> s_axi_bvalid_o) else $error("bvalid dropped early");

  cover property ($rose(s_axi_bvalid_o) && aw_q == CALH);
  cover property (s_axi_bvalid_o && !s_axi_bready_i);
  cover property (temp_adc_valid_i && temp_cal_subtract_o);
  cover property (temp_adc_valid_i && !temp_cal_subtract_o);
endmodule

bind tacb_trim_bank tacb_trim_bank_chk #(.ADDR_W(ADDR_W), .ADC_W(ADC_W))
  i_tacb_trim_bank_chk (
  .mclk_i, .resetn_i, .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_awaddr_i,
  .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_wdata_i, .s_axi_wstrb_i,
  .s_axi_bvalid_o, .s_axi_bready_i, .fast_crystal_trim_code_o,
  .slow_crystal_trim_code_o, .temp_cal_subtract_o, .temp_cal_magnitude_o,
  .temp_adc_valid_i, .temp_adc_i, .temp_corrected_valid_o, .temp_corrected_o);
